// ==== hdl/bic_bank_if.sv ====
// Purpose: Carries one bank's configuration, pulses and pending state.
// Assumes: Driven by the controller top, consumed by one bank.
// Notes:   All fields are one bit per source.
`timescale 1ns/1ns
interface bic_bank_if;
  logic [31:0] enable;
  logic [31:0] arm;
  logic [31:0] level;
  logic [31:0] polarity;
  logic [31:0] soft_set;
  logic [31:0] clear;
  logic [31:0] source;
  logic [31:0] pending;
  modport ctl  (output enable, arm, level, polarity, soft_set, clear, source, input pending);
  modport bank (input enable, arm, level, polarity, soft_set, clear, source, output pending);
endinterface : bic_bank_if

// ==== hdl/bic_defs.svh ====
// Purpose: Register map, field layout and route codes of the board interrupt controller.
// Assumes: 8-bit byte address on the register port, 32-bit registers.
// Notes:   Definitions only.
`ifndef BIC_DEFS_SVH
`define BIC_DEFS_SVH
`define BIC_OFS_EN_A    8'h10
`define BIC_OFS_EN_B    8'h14
`define BIC_OFS_REQ_A   8'h20
`define BIC_OFS_REQ_B   8'h24
`define BIC_OFS_PEND_A  8'h28
`define BIC_OFS_PEND_B  8'h2C
`define BIC_OFS_CLR_A   8'h30
`define BIC_OFS_CLR_B   8'h34
`define BIC_OFS_ARM_A   8'h40
`define BIC_OFS_ARM_B   8'h44
`define BIC_OFS_LVL_A   8'h50
`define BIC_OFS_LVL_B   8'h54
`define BIC_OFS_POL_A   8'h60
`define BIC_OFS_POL_B   8'h64
`define BIC_OFS_RT_0    8'h70
`define BIC_OFS_RT_1    8'h74
`define BIC_OFS_RT_2    8'h78
`define BIC_RST_CFG     32'h00000000
`define BIC_VALID_A     32'hFFF0FFFF
`define BIC_VALID_B     32'h0F000F00
`define BIC_ROUTE_VALID 32'h3F3F3F3F
`define BIC_POS_TMR     0
`define BIC_POS_TMR_HI  4
`define BIC_POS_EXT     8
`define BIC_POS_EXT_MID 12
`define BIC_POS_PPS     20
`define BIC_POS_CBL     24
`define BIC_POS_CBL_MID 28
`define BIC_RT_STRIDE   8
`define BIC_RC_FIRST    6'h04
`define BIC_RC_PPS      6'h20
// Route codes grouped by code bits 5..2; bits 1..0 pick one of four sources.
`define BIC_GRP_TMR_LO  4'h1
`define BIC_GRP_EXT_LO  4'h2
`define BIC_GRP_CBL_LO  4'h4
`define BIC_GRP_CBL_MID 4'h5
`define BIC_GRP_CBL_HI  4'h6
`define BIC_GRP_PPS     4'h8
`define BIC_GRP_TMR_HI  4'h9
`define BIC_GRP_EXT_MID 4'hA
`define BIC_GRP_EXT_HI  4'hE
`endif

// ==== hdl/bic_irq_bank.sv ====
// Purpose: Pending latches of one 32-source bank.
// Assumes: Sources already on clk_sys.
// Notes:   Reserved bits never latch.
`timescale 1ns/1ns
`include "bic_defs.svh"
module bic_irq_bank
  import bic_pkg::*;
#(
  parameter logic [31:0] VALID = `BIC_VALID_A
)(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  bic_bank_if.bank  bi
);
  bic_bank_st_t st_r;
  bic_bank_st_t st_nxt;
  logic [31:0]  act;
  logic [31:0]  edge_set;
  logic [31:0]  clr_only;

  always_comb
  begin
    st_nxt   = st_r;
    act      = bi.source ^ ~bi.polarity;
    edge_set = ~bi.level & bi.arm & act & ~st_r.act_prev & VALID;
    clr_only = bi.clear & ~bi.level & ~bi.soft_set & ~edge_set & VALID;
    st_nxt.act_prev = act;
    // Set wins over clear; level sources track the input and ignore clear.
    st_nxt.pend = ((st_r.pend & ~bi.clear & ~bi.level) | bi.soft_set | edge_set |
                   (bi.level & act)) & VALID;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign bi.pending = st_r.pend;

  a_edge_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (edge_set != 0) |=> ((st_r.pend & $past(edge_set)) == $past(edge_set)))
    else $error("armed edge not latched");
  a_clear_drops: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clr_only != 0) |=> ((st_r.pend & $past(clr_only)) == 0))
    else $error("cleared request still pending");
  a_level_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 ((st_r.pend & $past(bi.level) & VALID & ~$past(bi.soft_set)) ==
         ($past(act) & $past(bi.level) & VALID & ~$past(bi.soft_set))))
    else $error("level source pending does not follow input");
endmodule : bic_irq_bank

// ==== hdl/bic_pkg.sv ====
// Purpose: Types and the route decoder shared by the controller modules.
// Assumes: bic_defs.svh on the include path.
// Notes:   None.
package bic_pkg;
`include "bic_defs.svh"
  typedef struct packed {
    logic [31:0] act_prev;
    logic [31:0] pend;
  } bic_bank_st_t;
  typedef struct packed {
    logic [11:0] ext_out;
  } bic_route_st_t;
  typedef struct packed {
    logic [27:0]      sync_meta;
    logic [27:0]      sync_q;
    logic [31:0]      en_a;
    logic [31:0]      en_b;
    logic [31:0]      arm_a;
    logic [31:0]      arm_b;
    logic [31:0]      lvl_a;
    logic [31:0]      lvl_b;
    logic [31:0]      pol_a;
    logic [31:0]      pol_b;
    logic [2:0][31:0] route;
    logic [31:0]      rdata;
    logic             irq;
  } bic_top_st_t;

  // Reserved codes give an idle output: 21..23 through the pulse-per-second test, all others through the default.
  function automatic logic bic_pick(input logic [5:0] c, input logic [31:0] a,
                                    input logic [31:0] b);
    logic [1:0] k;
    k = c[1:0];
    case (c[5:2])
      `BIC_GRP_TMR_LO:  bic_pick = a[`BIC_POS_TMR + k];
      `BIC_GRP_EXT_LO:  bic_pick = a[`BIC_POS_EXT + k];
      `BIC_GRP_CBL_LO:  bic_pick = a[`BIC_POS_CBL + k];
      `BIC_GRP_CBL_MID: bic_pick = a[`BIC_POS_CBL_MID + k];
      `BIC_GRP_CBL_HI:  bic_pick = b[`BIC_POS_CBL + k];
      `BIC_GRP_PPS:     bic_pick = (c == `BIC_RC_PPS) & a[`BIC_POS_PPS];
      `BIC_GRP_TMR_HI:  bic_pick = a[`BIC_POS_TMR_HI + k];
      `BIC_GRP_EXT_MID: bic_pick = a[`BIC_POS_EXT_MID + k];
      `BIC_GRP_EXT_HI:  bic_pick = b[`BIC_POS_EXT + k];
      default:          bic_pick = 1'b0;
    endcase
  endfunction : bic_pick
endpackage : bic_pkg

// ==== hdl/bic_route.sv ====
// Purpose: Steers delivered sources onto the twelve connector outputs.
// Assumes: Delivered vectors are pending masked by enable.
// Notes:   Outputs are registered, one cycle behind the source.
`timescale 1ns/1ns
`include "bic_defs.svh"
module bic_route
  import bic_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [2:0][31:0] route_cfg,
  input  wire logic [31:0]      deliver_a,
  input  wire logic [31:0]      deliver_b,
  output logic      [11:0]      ext_out
);
  bic_route_st_t st_r;
  bic_route_st_t st_nxt;
  logic [11:0]   pick;

  for (genvar g = 0; g < 12; g++)
  begin : g_out
    assign pick[g] = bic_pick(route_cfg[g / 4][(g % 4) * `BIC_RT_STRIDE +: 6],
                              deliver_a, deliver_b);
  end

  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.ext_out = pick;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign ext_out = st_r.ext_out;

  a_rsv_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (route_cfg[0][5:0] < `BIC_RC_FIRST) |=> !ext_out[0])
    else $error("reserved route code drives output");
  a_pps_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (route_cfg[1][5:0] == `BIC_RC_PPS) |=> (ext_out[4] == $past(deliver_a[`BIC_POS_PPS])))
    else $error("pulse-per-second route wrong");
  c_route_active: cover property (@(posedge clk_sys) disable iff (sys_rst) ext_out != 0);
endmodule : bic_route

// ==== hdl/bic_top.sv ====
// Purpose: Board interrupt controller: two source banks, host interrupt and routing.
// Assumes: clk_sys at 250 MHz; timer requests come from logic on clk_sys.
// Notes:   Pin inputs pass a two-flop synchroniser before any logic sees them.
//
// How it works
// - Stored one means on, zero off.
// - Enable bit gates delivery of its source.
// - Writing request one raises a software request.
// - Pending registers show latched outstanding requests.
// - Writing clear one removes an edge source's outstanding request; level sources ignore it.
// - Armed edge sources latch on active edge.
// - Level bit one means level, zero edge.
// - Polarity one high or rising, zero low.
// - First bank holds timers, externals, auxiliaries, cables.
// - Second bank holds externals and cables eight-eleven.
// - Each connector output follows its routed source.
// - Three route registers, four six-bit fields each.
// - Route codes select timers, externals, cables, pulse.
`timescale 1ns/1ns
`include "bic_defs.svh"
module bic_top
  import bic_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [7:0]  timer_irq,
  input  wire logic [3:0]  satnav_aux_irq,
  input  wire logic [11:0] external_line_irq,
  input  wire logic [11:0] cable_line_irq,
  output logic             host_irq,
  output logic      [11:0] ext_irq_out
);
  // ***************************************************************
  // Declarations
  // ***************************************************************
  bic_top_st_t st_r;
  bic_top_st_t st_nxt;
  bic_bank_if  bi_a ();
  bic_bank_if  bi_b ();
  logic [11:0] ext_s;
  logic [11:0] cbl_s;
  logic [3:0]  aux_s;
  logic [31:0] soft_a;
  logic [31:0] soft_b;
  logic [31:0] clr_a;
  logic [31:0] clr_b;
  logic [31:0] deliver_a;
  logic [31:0] deliver_b;
  logic [31:0] rd_word;

  // ***************************************************************
  // Synchronised inputs
  // ***************************************************************
  // The second stage is the only reader of the first.
  assign ext_s = st_r.sync_q[11:0];
  assign cbl_s = st_r.sync_q[23:12];
  assign aux_s = st_r.sync_q[27:24];

  // ***************************************************************
  // Write pulses
  // ***************************************************************
  // Request and clear store nothing; a one written is a single-cycle pulse.
  always_comb
  begin
    soft_a = '0;
    soft_b = '0;
    clr_a  = '0;
    clr_b  = '0;
    if (reg_wr)
    begin
      case (reg_addr)
        `BIC_OFS_REQ_A: soft_a = reg_wdata & `BIC_VALID_A;
        `BIC_OFS_REQ_B: soft_b = reg_wdata & `BIC_VALID_B;
        `BIC_OFS_CLR_A: clr_a  = reg_wdata & `BIC_VALID_A;
        `BIC_OFS_CLR_B: clr_b  = reg_wdata & `BIC_VALID_B;
        default:
        begin
          soft_a = '0;
        end
      endcase
    end
  end

  // ***************************************************************
  // Read mux
  // ***************************************************************
  // Request and clear read back as zero; unmapped offsets read as zero.
  always_comb
  begin
    rd_word = '0;
    case (reg_addr)
      `BIC_OFS_EN_A:   rd_word = st_r.en_a;
      `BIC_OFS_EN_B:   rd_word = st_r.en_b;
      `BIC_OFS_PEND_A: rd_word = bi_a.pending;
      `BIC_OFS_PEND_B: rd_word = bi_b.pending;
      `BIC_OFS_ARM_A:  rd_word = st_r.arm_a;
      `BIC_OFS_ARM_B:  rd_word = st_r.arm_b;
      `BIC_OFS_LVL_A:  rd_word = st_r.lvl_a;
      `BIC_OFS_LVL_B:  rd_word = st_r.lvl_b;
      `BIC_OFS_POL_A:  rd_word = st_r.pol_a;
      `BIC_OFS_POL_B:  rd_word = st_r.pol_b;
      `BIC_OFS_RT_0:   rd_word = st_r.route[0];
      `BIC_OFS_RT_1:   rd_word = st_r.route[1];
      `BIC_OFS_RT_2:   rd_word = st_r.route[2];
      default:         rd_word = '0;
    endcase
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.sync_meta = {satnav_aux_irq, cable_line_irq, external_line_irq};
    st_nxt.sync_q    = st_r.sync_meta;
    st_nxt.rdata     = reg_rd ? rd_word : '0;
    // Host line is registered so it never glitches on the bus side.
    st_nxt.irq       = (deliver_a != 0) || (deliver_b != 0);
    if (reg_wr)
    begin
      // Reserved bits are not stored, so they always read as zero.
      case (reg_addr)
        `BIC_OFS_EN_A:  st_nxt.en_a     = reg_wdata & `BIC_VALID_A;
        `BIC_OFS_EN_B:  st_nxt.en_b     = reg_wdata & `BIC_VALID_B;
        `BIC_OFS_ARM_A: st_nxt.arm_a    = reg_wdata & `BIC_VALID_A;
        `BIC_OFS_ARM_B: st_nxt.arm_b    = reg_wdata & `BIC_VALID_B;
        `BIC_OFS_LVL_A: st_nxt.lvl_a    = reg_wdata & `BIC_VALID_A;
        `BIC_OFS_LVL_B: st_nxt.lvl_b    = reg_wdata & `BIC_VALID_B;
        `BIC_OFS_POL_A: st_nxt.pol_a    = reg_wdata & `BIC_VALID_A;
        `BIC_OFS_POL_B: st_nxt.pol_b    = reg_wdata & `BIC_VALID_B;
        `BIC_OFS_RT_0:  st_nxt.route[0] = reg_wdata & `BIC_ROUTE_VALID;
        `BIC_OFS_RT_1:  st_nxt.route[1] = reg_wdata & `BIC_ROUTE_VALID;
        `BIC_OFS_RT_2:  st_nxt.route[2] = reg_wdata & `BIC_ROUTE_VALID;
        default:
        begin
          st_nxt.irq = st_nxt.irq;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r          <= '0;
      st_r.en_a     <= `BIC_RST_CFG;
      st_r.en_b     <= `BIC_RST_CFG;
      st_r.arm_a    <= `BIC_RST_CFG;
      st_r.arm_b    <= `BIC_RST_CFG;
      st_r.lvl_a    <= `BIC_RST_CFG;
      st_r.lvl_b    <= `BIC_RST_CFG;
      st_r.pol_a    <= `BIC_RST_CFG;
      st_r.pol_b    <= `BIC_RST_CFG;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ***************************************************************
  // Bank wiring
  // ***************************************************************
  // Bank A: cables 7..0, auxiliaries 3..0, externals 7..0, timers 7..0.
  assign bi_a.enable   = st_r.en_a;
  assign bi_a.arm      = st_r.arm_a;
  assign bi_a.level    = st_r.lvl_a;
  assign bi_a.polarity = st_r.pol_a;
  assign bi_a.soft_set = soft_a;
  assign bi_a.clear    = clr_a;
  assign bi_a.source   = {cbl_s[7:0], aux_s, 4'h0, ext_s[7:0], timer_irq};
  // Bank B: cables 11..8 and externals 11..8 only.
  assign bi_b.enable   = st_r.en_b;
  assign bi_b.arm      = st_r.arm_b;
  assign bi_b.level    = st_r.lvl_b;
  assign bi_b.polarity = st_r.pol_b;
  assign bi_b.soft_set = soft_b;
  assign bi_b.clear    = clr_b;
  assign bi_b.source   = {4'h0, cbl_s[11:8], 12'h000, ext_s[11:8], 8'h00};

  bic_irq_bank #(
    .VALID (`BIC_VALID_A)
  ) u_bank_a (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .bi      (bi_a)
  );

  bic_irq_bank #(
    .VALID (`BIC_VALID_B)
  ) u_bank_b (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .bi      (bi_b)
  );

  // ***************************************************************
  // Delivery and routing
  // ***************************************************************
  // Routing uses delivered sources, so a disabled source stays off the connector too.
  assign deliver_a = bi_a.pending & st_r.en_a;
  assign deliver_b = bi_b.pending & st_r.en_b;

  bic_route u_route (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .route_cfg (st_r.route),
    .deliver_a (deliver_a),
    .deliver_b (deliver_b),
    .ext_out   (ext_irq_out)
  );

  assign host_irq  = st_r.irq;
  assign reg_rdata = st_r.rdata;

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_irq_raise: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((deliver_a != 0) || (deliver_b != 0)) |=> host_irq)
    else $error("host interrupt missing for enabled pending source");
  a_irq_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((deliver_a == 0) && (deliver_b == 0)) |=> !host_irq)
    else $error("host interrupt without enabled pending source");
  a_pend_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && (reg_addr == `BIC_OFS_PEND_A)) |=> (reg_rdata == $past(bi_a.pending)))
    else $error("pending read returns wrong word");
  a_soft_raise: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (soft_a != 0) |=> ((bi_a.pending & $past(soft_a)) == $past(soft_a)))
    else $error("software request not latched");
  a_enable_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && (reg_addr == `BIC_OFS_EN_B)) ##1 (reg_rd && (reg_addr == `BIC_OFS_EN_B))
    |=> (reg_rdata == ($past(reg_wdata, 2) & `BIC_VALID_B)))
    else $error("enable write not read back");
  a_rsv_bank_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && (reg_addr == `BIC_OFS_ARM_A)) |=> ((reg_rdata & ~`BIC_VALID_A) == 0))
    else $error("reserved bank A bits read nonzero");
  a_rsv_bank_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && (reg_addr == `BIC_OFS_PEND_B)) |=> ((reg_rdata & ~`BIC_VALID_B) == 0))
    else $error("reserved bank B bits read nonzero");
  a_read_once: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !reg_rd |=> (reg_rdata == 0))
    else $error("read data outside the answer cycle");
  a_route_timer: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_r.route[2][5:0] == `BIC_RC_FIRST) |=> (ext_irq_out[8] == $past(deliver_a[0])))
    else $error("timer 0 route wrong");

  c_host_irq: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(host_irq));
  c_soft_req: cover property (@(posedge clk_sys) disable iff (sys_rst)
    (soft_a != 0) ##2 host_irq);
  c_clear:    cover property (@(posedge clk_sys) disable iff (sys_rst)
    (clr_a != 0) ##2 !host_irq);
  c_cable_b:  cover property (@(posedge clk_sys) disable iff (sys_rst) deliver_b != 0);
endmodule : bic_top

// ==== tb/bic_line_model.sv ====
// Purpose: Far-side model of the external, cable and auxiliary interrupt lines.
// Assumes: The bench commands line levels on clk_sys.
// Notes:   Lines move 1 ns after the edge, so the design sees them as asynchronous.
`timescale 1ns/1ns
module bic_line_model
(
  input  wire logic        clk_sys,
  input  wire logic [11:0] ext_cmd,
  input  wire logic [11:0] cbl_cmd,
  input  wire logic [3:0]  aux_cmd,
  output logic      [11:0] external_line_irq,
  output logic      [3:0]  satnav_aux_irq,
  output logic      [11:0] cable_line_irq
);
  initial
  begin
    external_line_irq = 12'h000;
    satnav_aux_irq    = 4'h0;
    cable_line_irq    = 12'h000;
  end

  // A real line never lines up with the board clock, so keep it off the edge.
  always @(posedge clk_sys)
  begin
    #1;
    external_line_irq = ext_cmd;
    satnav_aux_irq    = aux_cmd;
    cable_line_irq    = cbl_cmd;
  end
endmodule : bic_line_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench of the board interrupt controller.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes:   Register rows first, then edge, request, level, routing and reset tests.
`timescale 1ns/1ns
`include "bic_defs.svh"
module testbench
  import bic_pkg::*;
;
  logic        clk_sys   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  timer_irq = 8'h00;
  logic [11:0] ext_cmd   = 12'h000;
  logic [11:0] cbl_cmd   = 12'h000;
  logic [3:0]  aux_cmd   = 4'h0;
  logic [31:0] reg_rdata;
  logic [11:0] external_line_irq;
  logic [11:0] cable_line_irq;
  logic [3:0]  satnav_aux_irq;
  logic        host_irq;
  logic [11:0] ext_irq_out;
  logic [31:0] v;
  int          err_total = 0;
  int          n_checks  = 0;

  // Unmapped and read-only places lead so that no level setting disturbs them.
  logic [7:0]  row_addr [14] = '{`BIC_OFS_PEND_A, 8'h0C, 8'h80, `BIC_OFS_EN_A, `BIC_OFS_EN_B,
    `BIC_OFS_ARM_A, `BIC_OFS_ARM_B, `BIC_OFS_LVL_A, `BIC_OFS_LVL_B, `BIC_OFS_POL_A,
    `BIC_OFS_POL_B, `BIC_OFS_RT_0, `BIC_OFS_RT_1, `BIC_OFS_RT_2};
  logic [31:0] row_exp [14] = '{32'h00000000, 32'h00000000, 32'h00000000, 32'hFFF0FFFF,
    32'h0F000F00, 32'hFFF0FFFF, 32'h0F000F00, 32'hFFF0FFFF, 32'h0F000F00, 32'hFFF0FFFF,
    32'h0F000F00, 32'h3F3F3F3F, 32'h3F3F3F3F, 32'h3F3F3F3F};

  always #2 clk_sys = ~clk_sys;

  bic_top bic_top_i (
    .clk_sys           (clk_sys),
    .sys_rst           (sys_rst),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .timer_irq         (timer_irq),
    .satnav_aux_irq    (satnav_aux_irq),
    .external_line_irq (external_line_irq),
    .cable_line_irq    (cable_line_irq),
    .host_irq          (host_irq),
    .ext_irq_out       (ext_irq_out)
  );

  bic_line_model bic_line_model_i (
    .clk_sys           (clk_sys),
    .ext_cmd           (ext_cmd),
    .cbl_cmd           (cbl_cmd),
    .aux_cmd           (aux_cmd),
    .external_line_irq (external_line_irq),
    .satnav_aux_irq    (satnav_aux_irq),
    .cable_line_irq    (cable_line_irq)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle(1);
    chk("host_irq", host_irq, 32'h0);
    for (int i = 0; i < 14; i++)
    begin
      rd(row_addr[i], v);
      chk($sformatf("reset %h", row_addr[i]), v, 32'h0);
      wr(row_addr[i], 32'hFFFFFFFF);
      rd(row_addr[i], v);
      chk($sformatf("readback %h", row_addr[i]), v, row_exp[i]);
      wr(row_addr[i], 32'h0);
    end
    wr(`BIC_OFS_CLR_A, 32'hFFFFFFFF);
    wr(`BIC_OFS_CLR_B, 32'hFFFFFFFF);
    $display("done: registers");
    // Disarmed edge first, then armed rising, falling, timer and cable edges.
    wr(`BIC_OFS_POL_A, 32'h00000108);
    wr(`BIC_OFS_POL_B, 32'h01000000);
    @(posedge clk_sys);
    ext_cmd <= 12'h001;
    settle(6);
    rd(`BIC_OFS_PEND_A, v);
    chk("pend_a disarmed", v, 32'h0);
    @(posedge clk_sys);
    ext_cmd <= 12'h000;
    wr(`BIC_OFS_ARM_A, 32'h00000308);
    wr(`BIC_OFS_ARM_B, 32'h01000000);
    @(posedge clk_sys);
    ext_cmd   <= 12'h003;
    cbl_cmd   <= 12'h100;
    timer_irq <= 8'h08;
    settle(6);
    rd(`BIC_OFS_PEND_A, v);
    chk("pend_a rising", v, 32'h00000108);
    rd(`BIC_OFS_PEND_B, v);
    chk("pend_b cable", v, 32'h01000000);
    @(posedge clk_sys);
    ext_cmd <= 12'h001;
    settle(6);
    rd(`BIC_OFS_PEND_A, v);
    chk("pend_a falling", v, 32'h00000308);
    chk("host_irq disabled", host_irq, 32'h0);
    wr(`BIC_OFS_EN_A, 32'h00000200);
    settle(3);
    chk("host_irq enabled", host_irq, 32'h1);
    wr(`BIC_OFS_CLR_A, 32'h00000200);
    settle(3);
    chk("host_irq cleared", host_irq, 32'h0);
    rd(`BIC_OFS_PEND_A, v);
    chk("pend_a cleared", v, 32'h00000108);
    $display("done: edges");
    wr(`BIC_OFS_CLR_A, 32'hFFFFFFFF);
    wr(`BIC_OFS_CLR_B, 32'hFFFFFFFF);
    wr(`BIC_OFS_REQ_A, 32'h00010001);
    wr(`BIC_OFS_REQ_B, 32'hFFFFFFFF);
    rd(`BIC_OFS_PEND_A, v);
    chk("pend_a request", v, 32'h00000001);
    rd(`BIC_OFS_PEND_B, v);
    chk("pend_b request", v, 32'h0F000F00);
    wr(`BIC_OFS_CLR_A, 32'hFFFFFFFF);
    wr(`BIC_OFS_CLR_B, 32'hFFFFFFFF);
    $display("done: requests");
    // Level mode: clear has no hold on a live level.
    wr(`BIC_OFS_LVL_A, 32'h00100400);
    wr(`BIC_OFS_POL_A, 32'h00100508);
    wr(`BIC_OFS_EN_A, 32'h00100400);
    @(posedge clk_sys);
    ext_cmd <= 12'h005;
    aux_cmd <= 4'h1;
    settle(6);
    chk("host_irq level", host_irq, 32'h1);
    wr(`BIC_OFS_CLR_A, 32'h00100400);
    rd(`BIC_OFS_PEND_A, v);
    chk("pend_a level", v, 32'h00100400);
    @(posedge clk_sys);
    ext_cmd <= 12'h001;
    aux_cmd <= 4'h0;
    settle(6);
    rd(`BIC_OFS_PEND_A, v);
    chk("pend_a level gone", v, 32'h0);
    chk("host_irq level gone", host_irq, 32'h0);
    $display("done: levels");
    // Every source pending except timer 1, with good and reserved codes mixed.
    wr(`BIC_OFS_LVL_A, 32'h0);
    wr(`BIC_OFS_EN_A, 32'hFFFFFFFF);
    wr(`BIC_OFS_EN_B, 32'hFFFFFFFF);
    wr(`BIC_OFS_REQ_A, 32'hFFFFFFFF);
    wr(`BIC_OFS_REQ_B, 32'hFFFFFFFF);
    wr(`BIC_OFS_CLR_A, 32'h00000002);
    wr(`BIC_OFS_RT_0, 32'h24200004);
    wr(`BIC_OFS_RT_1, 32'h101C3B21);
    wr(`BIC_OFS_RT_2, 32'h032B0805);
    settle(3);
    chk("ext_irq_out", {20'h0, ext_irq_out}, 32'h000006AD);
    chk("host_irq all", host_irq, 32'h1);
    // Pulse-per-second on output 4 and timer 0 on output 8.
    wr(`BIC_OFS_RT_1, 32'h101C3B20);
    wr(`BIC_OFS_RT_2, 32'h032B0804);
    settle(3);
    chk("ext_irq_out pps timer", {20'h0, ext_irq_out}, 32'h000007BD);
    wr(`BIC_OFS_EN_A, 32'h0);
    settle(3);
    chk("ext_irq_out bank b", {20'h0, ext_irq_out}, 32'h00000020);
    $display("done: routing");
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    settle(2);
    chk("ext_irq_out reset", {20'h0, ext_irq_out}, 32'h0);
    chk("host_irq reset", host_irq, 32'h0);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`BIC_OFS_EN_B, v);
    chk("en_b reset", v, 32'h0);
    rd(`BIC_OFS_PEND_B, v);
    chk("pend_b reset", v, 32'h0);
    // Write and read on consecutive edges, as the bus allows.
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= `BIC_OFS_EN_B;
    reg_wdata <= 32'hFFFFFFFF;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk("en_b back to back", reg_rdata, `BIC_VALID_B);
    $display("done: reset");
    conclude();
  end

  // The sequence needs well under 3000 cycles; this leaves ample slack.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    $display("watchdog expired");
    conclude();
  end
endmodule : testbench
